// ---- verilog/card_session_defs.vh ----
// Constants for the smart card session controller: register offsets,
// field positions, reset values and timing counts.
// Assumes a 250 MHz core clock; every count below is derived from it.
`ifndef CARD_SESSION_DEFS_VH
`define CARD_SESSION_DEFS_VH

// Core clock rate in MHz.
`define CLK_MHZ 250
// Power-on lockout after the digital supply becomes good, in ms.
`define LOCKOUT_TIME_MS 10
// Sized to the timer so that no parameter takes a wider value: 10 ms at 250 MHz.
`define LOCKOUT_CYCLES 24'h2625A0
// Duration of each sequencer step, in ns (least time, rounded up).
`define STEP_TIME_NS 1000
// Sized to the timer as well: 1000 ns at 250 MHz.
`define STEP_CYCLES 24'h0000FA
// Width of the sequencer timer.
`define TIMER_W 24

// Register byte offsets.
`define REG_STATUS 4'h0
`define REG_EVENT 4'h4
`define REG_MASK 4'h8

// Status register fields.
`define ST_SESSION_BIT 0
`define ST_PRESENT_BIT 1
`define ST_FAULT_N_BIT 2
`define ST_READY_BIT 3
`define ST_VCC5_BIT 4

// Event and mask register fields.
`define EV_ACT_DONE_BIT 0
`define EV_DEACT_DONE_BIT 1
`define EV_FAULT_BIT 2
`define EV_PRESENCE_BIT 3
`define EV_W 4
`define MASK_RESET 4'h0

`endif

// ---- verilog/sync_flops.v ----
// Two-flop synchroniser for a group of level signals.
// Assumes inputs may change at any time relative to mclk.
`default_nettype none

module sync_flops #(
  parameter W = 3
) (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Data
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);

  reg [W-1:0] meta_reg;

  // The first stage feeds only the second stage, so metastability has a full cycle to settle.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= {W{1'b1}};
      dout <= {W{1'b1}};
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end

endmodule // sync_flops

`default_nettype wire

// ---- verilog/card_session_ctrl.v ----
// Session control and supervision for a single-slot asynchronous smart card interface,
// with an Avalon-MM register slave and one level interrupt.
// Assumes arst_n comes from the digital supply supervisor and card status inputs are
// synchronous to mclk; the three host pins are asynchronous.
`default_nettype none
`include "card_session_defs.vh"

module card_session_ctrl #(
  parameter [`TIMER_W-1:0] LOCKOUT_CYCLES = `LOCKOUT_CYCLES
) (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Host control pins
  input wire session_request_n,
  input wire host_card_reset_req,
  input wire card_supply_select,
  output reg fault_ind_n,
  // Card side status from the analog front end
  input wire card_present,
  input wire vcc_valid,
  input wire vdd_fault,
  input wire over_current,
  // Card side controls
  output reg card_vcc_en,
  output reg card_vcc_5v,
  output reg card_io_rx_en,
  output reg card_clk_en,
  output reg card_rst,
  // Avalon-MM slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Interrupt
  output reg irq
);

  localparam [`TIMER_W-1:0] STEP_CYCLES = `STEP_CYCLES;
  localparam [9:0] ST_LOCK = 10'h001;
  localparam [9:0] ST_IDLE = 10'h002;
  localparam [9:0] ST_RAMP = 10'h004;
  localparam [9:0] ST_IO = 10'h008;
  localparam [9:0] ST_CLK = 10'h010;
  localparam [9:0] ST_ACT = 10'h020;
  localparam [9:0] ST_DRST = 10'h040;
  localparam [9:0] ST_DCLK = 10'h080;
  localparam [9:0] ST_DIO = 10'h100;
  localparam [9:0] ST_DVCC = 10'h200;

  wire req_n_sync, rst_req_sync, sel_sync;
  reg req_n_prev_reg;
  reg [9:0] state_reg;
  reg [9:0] state_next;
  reg [`TIMER_W-1:0] timer_reg;
  reg [`TIMER_W-1:0] timer_next;
  reg fault_latch_reg;
  reg present_prev_reg;
  reg present_armed_reg;
  reg [`EV_W-1:0] event_reg;
  reg [`EV_W-1:0] mask_reg;
  reg [`EV_W-1:0] event_set;
  reg [31:0] rdata_next;
  wire req_fall, tmr_zero, in_session, vcc_checked;
  wire fault_now, ramp_fail, abort, ack, fault_ind_n_next;

  // Host pins cross into the mclk domain before any use.
  sync_flops #(
    .W(3)
  ) u_host_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .din({session_request_n, host_card_reset_req, card_supply_select}),
    .dout({req_n_sync, rst_req_sync, sel_sync})
  );

  // Edge of the synchronised request, one pulse per falling edge.
  assign req_fall = req_n_prev_reg & ~req_n_sync;
  assign tmr_zero = (timer_reg == {`TIMER_W{1'b0}});

  // A session spans the states between the start of activation and the start of teardown.
  assign in_session = |(state_reg & (ST_RAMP | ST_IO | ST_CLK | ST_ACT));
  assign vcc_checked = |(state_reg & (ST_IO | ST_CLK | ST_ACT));
  // Faults count only inside a session with the request still low.
  assign fault_now = in_session & ~req_n_sync &
    (~card_present | vdd_fault | over_current | (vcc_checked & ~vcc_valid));
  // The supply is checked once at the end of the ramp step.
  assign ramp_fail = (state_reg == ST_RAMP) & tmr_zero & ~vcc_valid & ~req_n_sync;
  // Host release or any fault tears the session down.
  assign abort = req_n_sync | fault_now;

  // Next state of the sequencer.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_LOCK: begin
        if (tmr_zero) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (vdd_fault) begin
          state_next = ST_LOCK;
        end else if (req_fall && card_present) begin
          state_next = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (abort) begin
          state_next = ST_DRST;
        end else if (ramp_fail) begin
          state_next = ST_DVCC;
        end else if (tmr_zero) begin
          state_next = ST_IO;
        end
      end
      ST_IO: begin
        if (abort) begin
          state_next = ST_DRST;
        end else if (tmr_zero) begin
          state_next = ST_CLK;
        end
      end
      ST_CLK: begin
        // With the reset request high the clock waits for its fall.
        if (abort) begin
          state_next = ST_DRST;
        end else if (tmr_zero && !rst_req_sync) begin
          state_next = ST_ACT;
        end
      end
      ST_ACT: begin
        if (abort) begin
          state_next = ST_DRST;
        end
      end
      ST_DRST: begin
        if (tmr_zero) begin
          state_next = ST_DCLK;
        end
      end
      ST_DCLK: begin
        if (tmr_zero) begin
          state_next = ST_DIO;
        end
      end
      ST_DIO: begin
        if (tmr_zero) begin
          state_next = ST_DVCC;
        end
      end
      ST_DVCC: begin
        if (tmr_zero) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_LOCK;
      end
    endcase
  end

  // The timer reloads on every state change; lockout uses the long count.
  always @* begin
    timer_next = tmr_zero ? timer_reg : timer_reg - {{(`TIMER_W-1){1'b0}}, 1'b1};
    if (state_next != state_reg) begin
      timer_next = (state_next == ST_LOCK) ? LOCKOUT_CYCLES : STEP_CYCLES;
    end
  end

  // Indication line: presence while the request is high, fault while it is low.
  assign fault_ind_n_next = req_n_sync ? card_present :
    ~(fault_latch_reg | fault_now | ramp_fail);

  // Sequencer state, card outputs and indication line.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_LOCK;
      timer_reg <= LOCKOUT_CYCLES;
      req_n_prev_reg <= 1'b1;
      fault_latch_reg <= 1'b0;
      fault_ind_n <= 1'b0;
      card_vcc_en <= 1'b0;
      card_vcc_5v <= 1'b0;
      card_io_rx_en <= 1'b0;
      card_clk_en <= 1'b0;
      card_rst <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      req_n_prev_reg <= req_n_sync;
      // The fault stays reported until the host ends the session.
      if (req_n_sync) begin
        fault_latch_reg <= 1'b0;
      end else if (fault_now || ramp_fail) begin
        fault_latch_reg <= 1'b1;
      end
      fault_ind_n <= fault_ind_n_next;
      if (state_reg == ST_IDLE && state_next == ST_RAMP) begin
        card_vcc_5v <= sel_sync;
      end
      // Outputs follow the next state so each step changes exactly at its own edge.
      card_vcc_en <= |(state_next & (ST_RAMP | ST_IO | ST_CLK | ST_ACT |
        ST_DRST | ST_DCLK | ST_DIO));
      card_io_rx_en <= |(state_next & (ST_IO | ST_CLK | ST_ACT | ST_DRST | ST_DCLK));
      card_clk_en <= |(state_next & (ST_ACT | ST_DRST));
      card_rst <= (state_next == ST_ACT) & rst_req_sync;
    end
  end

  // Events raised this cycle.
  always @* begin
    event_set = {`EV_W{1'b0}};
    event_set[`EV_ACT_DONE_BIT] = (state_next == ST_ACT) && (state_reg != ST_ACT);
    event_set[`EV_DEACT_DONE_BIT] = (state_reg == ST_DVCC) && (state_next == ST_IDLE);
    event_set[`EV_FAULT_BIT] = fault_ind_n & ~fault_ind_n_next & ~req_n_sync;
    event_set[`EV_PRESENCE_BIT] = (present_prev_reg ^ card_present) & present_armed_reg;
  end

  // Bus answer comes one cycle after the request is seen.
  assign ack = (avs_read | avs_write) & avs_waitrequest;

  // Read data mux; unmapped offsets read as zero.
  always @* begin
    rdata_next = 32'h00000000;
    case (avs_address)
      `REG_STATUS: begin
        rdata_next[`ST_SESSION_BIT] = in_session;
        rdata_next[`ST_PRESENT_BIT] = card_present;
        rdata_next[`ST_FAULT_N_BIT] = fault_ind_n;
        rdata_next[`ST_READY_BIT] = (state_reg == ST_IDLE);
        rdata_next[`ST_VCC5_BIT] = card_vcc_5v;
      end
      `REG_EVENT: begin
        rdata_next[`EV_W-1:0] = event_reg;
      end
      `REG_MASK: begin
        rdata_next[`EV_W-1:0] = mask_reg;
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  // Register slave, sticky events and interrupt.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      event_reg <= {`EV_W{1'b0}};
      mask_reg <= `MASK_RESET;
      present_prev_reg <= 1'b0;
      present_armed_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      avs_waitrequest <= ~ack;
      present_prev_reg <= card_present;
      present_armed_reg <= 1'b1; // The first edge after reset holds no true change.
      if (ack && avs_read) begin
        avs_readdata <= rdata_next;
      end
      if (ack && avs_write && avs_address == `REG_MASK) begin
        mask_reg <= avs_writedata[`EV_W-1:0];
      end
      // A read of the event register clears the events, but one arriving in the same cycle survives.
      if (ack && avs_read && avs_address == `REG_EVENT) begin
        event_reg <= event_set;
      end else begin
        event_reg <= event_reg | event_set;
      end
      irq <= |((event_reg | event_set) & mask_reg);
    end
  end

endmodule // card_session_ctrl

`default_nettype wire

// ---- bench/session_chk_sva.sv ----
// Checker for the card session controller ports.
// Assumes it is bound to every instance of the controller.
`default_nettype none
module session_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Host pins
  input wire logic session_request_n,
  input wire logic host_card_reset_req,
  input wire logic card_supply_select,
  input wire logic fault_ind_n,
  // Card side
  input wire logic card_present,
  input wire logic over_current,
  input wire logic card_vcc_en,
  input wire logic card_vcc_5v,
  input wire logic card_io_rx_en,
  input wire logic card_clk_en,
  input wire logic card_rst,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Four cycles cover the two synchroniser flops and the output register.
  property p_presence;
    (session_request_n && (fault_ind_n != card_present))[*4] |-> 1'b0;
  endproperty
  a_presence: assert property (p_presence) else $error("indication not presence");
  property p_fault;
    (!session_request_n)[*3] ##0 (card_clk_en && over_current) |=> !fault_ind_n;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not shown");
  // Three teardown steps of about 251 cycles each end well inside this window.
  property p_auto_off;
    $fell(fault_ind_n) && card_vcc_en |-> ##[1:1000] !card_vcc_en;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("no deactivation");
  property p_on_order;
    ($rose(card_io_rx_en) |-> card_vcc_en) and ($rose(card_clk_en) |-> card_io_rx_en);
  endproperty
  a_on_order: assert property (p_on_order) else $error("activation order");
  property p_rst_gate;
    card_rst |-> card_clk_en && card_io_rx_en && card_vcc_en;
  endproperty
  a_rst_gate: assert property (p_rst_gate) else $error("reset outside session");
  property p_rst_follow;
    (!host_card_reset_req)[*4] |-> !card_rst;
  endproperty
  a_rst_follow: assert property (p_rst_follow) else $error("reset not following");
  property p_off_order;
    ($fell(card_clk_en) |-> !card_rst) and ($fell(card_io_rx_en) |-> !card_clk_en)
      and ($fell(card_vcc_en) |-> !card_io_rx_en);
  endproperty
  a_off_order: assert property (p_off_order) else $error("deactivation order");
  property p_level;
    $rose(card_vcc_en) |-> card_vcc_5v == $past(card_supply_select, 3);
  endproperty
  a_level: assert property (p_level) else $error("supply level");
  property p_idle;
    (session_request_n && !card_vcc_en)[*4] |=> !card_vcc_en;
  endproperty
  a_idle: assert property (p_idle) else $error("supply on outside session");
  property p_bus;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer timing");
endmodule // session_chk
bind card_session_ctrl session_chk u_chk (.mclk, .arst_n, .session_request_n,
  .host_card_reset_req, .card_supply_select, .fault_ind_n, .card_present, .over_current,
  .card_vcc_en, .card_vcc_5v, .card_io_rx_en, .card_clk_en, .card_rst, .avs_read,
  .avs_write, .avs_waitrequest);
`default_nettype wire

// ---- bench/host_model.sv ----
// Host controller model driving the three control pins.
// Assumes its tasks are called just after a rising mclk edge.
`default_nettype none
module host_model (
  // Clock
  input wire logic mclk,
  // Control pins
  output var logic session_request_n,
  output var logic host_card_reset_req,
  output var logic card_supply_select
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle pins: no request, no card reset.
  initial begin
    session_request_n = 1'b1;
    host_card_reset_req = 1'b0;
    card_supply_select = 1'b0;
  end
  // The level is settled well before the request edge, as the sequencer latches it.
  task automatic open_s(input logic sel);
    @(posedge mclk) card_supply_select <= sel;
    repeat (4) @(posedge mclk);
    session_request_n <= 1'b0;
  endtask
  // Releasing the request asks for deactivation.
  task automatic close_s();
    @(posedge mclk) session_request_n <= 1'b1;
  endtask
  // Card reset request level.
  task automatic set_rst(input logic v);
    @(posedge mclk) host_card_reset_req <= v;
  endtask
endmodule // host_model
`default_nettype wire

// ---- bench/test_card_session_ctrl.sv ----
// Self-checking bench for the card session controller.
// Assumes the host model drives the pins and the bench plays the analog front end.
`default_nettype none
`include "card_session_defs.vh"
module test_card_session_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, arst_n, card_present, vcc_valid, vdd_fault, over_current, avs_read, avs_write, sel;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, rd;
  wire session_request_n, host_card_reset_req, card_supply_select, fault_ind_n, irq;
  wire card_vcc_en, card_vcc_5v, card_io_rx_en, card_clk_en, card_rst, avs_waitrequest;
  wire [31:0] avs_readdata;
  int error_cnt, checks_done, seed, cyc;
  host_model hm (.mclk, .session_request_n, .host_card_reset_req, .card_supply_select);
  // A short lockout keeps the run brief.
  card_session_ctrl #(.LOCKOUT_CYCLES(24'h14)) u_dut (.mclk, .arst_n, .session_request_n,
    .host_card_reset_req, .card_supply_select, .fault_ind_n, .card_present, .vcc_valid,
    .vdd_fault, .over_current, .card_vcc_en, .card_vcc_5v, .card_io_rx_en, .card_clk_en,
    .card_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .irq);
  // Free running 250 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Compare tasks for bits and for words.
  task automatic chk(input string nm, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %b got %b", nm, exp, got);
    end
  endtask
  task automatic chkw(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One bus transfer, held until the edge that sees waitrequest low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic pick(int k);
    pick = (k == 0) ? card_vcc_en : (k == 1) ? card_clk_en : fault_ind_n;
  endfunction
  // Waits a bounded time for a card supply, card clock or indication level, then compares it.
  task automatic wait_on(input int k, input logic v);
    int n;
    n = 0;
    while (pick(k) !== v && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    chk("wait", v, pick(k));
  endtask
  // The host must not request before the sequencer reports ready.
  task automatic wait_rdy();
    rd = 32'h0;
    while (rd[`ST_READY_BIT] !== 1'b1) bus(1'b0, `REG_STATUS, 32'h0, rd);
  endtask
  // A hang is cut short and counted as a mismatch.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // Main sequence: lockout, five sessions each ending a different way, idle presence, registers.
  initial begin
    seed = 37;
    {arst_n, avs_read, avs_write, vdd_fault, over_current} = 5'h0;
    {card_present, vcc_valid, avs_address, avs_writedata} = 38'h3_0_00000000;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    hm.open_s(1'b0);
    repeat (20) @(posedge mclk);
    chk("lockout", 1'b0, card_vcc_en);
    bus(1'b0, `REG_MASK, 32'h0, rd);
    chkw("mask_rst", 32'h0, rd);
    hm.close_s();
    for (int k = 0; k < 5; k++) begin
      sel = (k < 2) ? k[0] : 1'($random(seed));
      wait_rdy();
      vcc_valid <= (k != 4);
      // Session 3 opens with the reset request high, so the clock must wait for its fall.
      if (k == 3) hm.set_rst(1'b1);
      hm.open_s(sel);
      wait_on(0, 1'b1);
      chk("vcc_5v", sel, card_vcc_5v);
      if (k == 4) begin
        wait_on(2, 1'b0);
        wait_on(0, 1'b0);
        chk("io_rx", 1'b0, card_io_rx_en);
      end else begin
        if (k == 3) begin
          repeat (800) @(posedge mclk);
          chk("clk_held", 1'b0, card_clk_en);
          hm.set_rst(1'b0);
        end
        wait_on(1, 1'b1);
        hm.set_rst(1'b1);
        repeat (6) @(posedge mclk);
        chk("card_rst", 1'b1, card_rst);
        bus(1'b0, `REG_STATUS, 32'h0, rd);
        chkw("status", {27'h0, sel, 4'h7}, rd);
        case (k)
          0: hm.close_s();
          1: over_current <= 1'b1;
          2: card_present <= 1'b0;
          default: vdd_fault <= 1'b1;
        endcase
        repeat (3) @(posedge mclk);
        if (k != 0) chk("fault_ind", 1'b0, fault_ind_n);
        wait_on(0, 1'b0);
      end
      hm.close_s();
      hm.set_rst(1'b0);
      {over_current, vdd_fault, card_present} <= 3'h1;
    end
    // Let the loop's last clean-up land before the same pins change again.
    @(posedge mclk);
    over_current <= 1'b1;
    card_present <= 1'b0;
    repeat (5) @(posedge mclk);
    chk("idle_absent", 1'b0, fault_ind_n);
    card_present <= 1'b1;
    repeat (5) @(posedge mclk);
    chk("idle_present", 1'b1, fault_ind_n);
    chk("idle_vcc", 1'b0, card_vcc_en);
    over_current <= 1'b0;
    chk("irq_masked", 1'b0, irq);
    bus(1'b1, `REG_MASK, 32'h2, rd);
    repeat (2) @(posedge mclk);
    chk("irq_on", 1'b1, irq);
    bus(1'b0, `REG_EVENT, 32'h0, rd);
    chkw("event", 32'hF, rd);
    repeat (2) @(posedge mclk);
    chk("irq_off", 1'b0, irq);
    bus(1'b1, 4'hC, 32'hF, rd);
    bus(1'b0, 4'hC, 32'h0, rd);
    chkw("unmapped", 32'h0, rd);
    bus(1'b0, `REG_MASK, 32'h0, rd);
    chkw("mask", 32'h2, rd);
    give_verdict();
  end
endmodule // test_card_session_ctrl
`default_nettype wire
